// file: hdl/memory_region_guard.sv
// Region protection unit between core access path and memory
`timescale 1ns/100ps
module memory_region_guard #(
	parameter int ADDR_W      = 32,
	parameter int DATA_W      = 32,
	parameter int NUM_REGIONS = 8
) (
	// Clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    rst_b,
	// Region configuration
	input  wire logic                    cfg_we,
	input  wire logic [2:0]              cfg_idx,
	input  wire logic                    cfg_en,
	input  wire logic [ADDR_W-1:0]       cfg_base,
	input  wire logic [4:0]              cfg_size,
	input  wire logic [7:0]              cfg_sub_dis,
	input  wire logic [1:0]              cfg_perm,
	// Core request
	input  wire logic                    req_valid,
	input  wire logic [ADDR_W-1:0]       req_addr,
	input  wire logic                    req_write,
	input  wire logic [DATA_W-1:0]       req_wdata,
	output logic                         req_ready_r,
	// Core answer
	output logic                         resp_done_r,
	output logic [DATA_W-1:0]            resp_rdata_r,
	output logic                         fault_r,
	output logic [ADDR_W-1:0]            fault_addr_r,
	output logic                         fault_write_r,
	// Memory side
	output logic                         mem_valid_r,
	output logic [ADDR_W-1:0]            mem_addr_r,
	output logic                         mem_write_r,
	output logic [DATA_W-1:0]            mem_wdata_r,
	input  wire logic                    mem_ready,
	input  wire logic [DATA_W-1:0]       mem_rdata
);

	// ---------------------------------------------------------------
	// Elaboration checks
	// ---------------------------------------------------------------
	if (NUM_REGIONS < 1 || NUM_REGIONS > region_guard_pkg::MAX_REGIONS) begin : g_bad_regions
		$error("NUM_REGIONS out of range");
	end
	if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W out of range");
	end

	// ---------------------------------------------------------------
	// Region settings
	// ---------------------------------------------------------------
	logic                    cfg_en_r      [NUM_REGIONS];
	logic [ADDR_W-1:0]       cfg_base_r    [NUM_REGIONS];
	logic [4:0]              cfg_size_r    [NUM_REGIONS];
	logic [7:0]              cfg_sub_dis_r [NUM_REGIONS];
	logic [1:0]              cfg_perm_r    [NUM_REGIONS];
	logic                    cfg_hit_w;

	assign cfg_hit_w = cfg_we && (int'(cfg_idx) < NUM_REGIONS);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_REGIONS; i++) begin
				cfg_en_r[i]      <= region_guard_pkg::REGION_EN_RST;
				cfg_base_r[i]    <= '0;
				cfg_size_r[i]    <= region_guard_pkg::SIZE_RST;
				cfg_sub_dis_r[i] <= region_guard_pkg::SUB_DIS_RST;
				cfg_perm_r[i]    <= region_guard_pkg::PERM_RST;
			end
		end else if (cfg_hit_w) begin
			cfg_en_r[cfg_idx]      <= cfg_en;
			cfg_base_r[cfg_idx]    <= cfg_base;
			cfg_size_r[cfg_idx]    <= cfg_size;
			cfg_sub_dis_r[cfg_idx] <= cfg_sub_dis;
			cfg_perm_r[cfg_idx]    <= cfg_perm;
		end
	end

	// ---------------------------------------------------------------
	// Region matchers
	// ---------------------------------------------------------------
	logic [NUM_REGIONS-1:0]  in_range_w;
	logic [NUM_REGIONS-1:0]  hit_w;
	logic [NUM_REGIONS-1:0]  allow_w;
	logic [2:0]              sub_idx_w     [NUM_REGIONS];

	for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_region
		region_matcher #(
			.ADDR_W    (ADDR_W)
		) u_match (
			.addr      (req_addr),
			.write     (req_write),
			.region_en (cfg_en_r[g]),
			.base      (cfg_base_r[g]),
			.size_log2 (cfg_size_r[g]),
			.sub_dis   (cfg_sub_dis_r[g]),
			.perm      (cfg_perm_r[g]),
			.in_range  (in_range_w[g]),
			.hit       (hit_w[g]),
			.allow     (allow_w[g]),
			.sub_idx   (sub_idx_w[g])
		);
	end

	// Highest numbered hitting region decides
	logic                    any_hit_w;
	logic                    sel_allow_w;
	logic [1:0]              sel_perm_w;

	always_comb begin
		any_hit_w   = 1'b0;
		sel_allow_w = 1'b0;
		sel_perm_w  = region_guard_pkg::PERM_NONE;
		for (int i = 0; i < NUM_REGIONS; i++) begin
			if (hit_w[i]) begin
				any_hit_w   = 1'b1;
				sel_allow_w = allow_w[i];
				sel_perm_w  = cfg_perm_r[i];
			end
		end
	end

	// ---------------------------------------------------------------
	// Access decision
	// ---------------------------------------------------------------
	logic                    take_w;
	logic                    pass_w;
	logic                    mem_end_w;

	assign take_w    = req_valid && req_ready_r;
	assign pass_w    = any_hit_w && sel_allow_w;
	assign mem_end_w = mem_valid_r && mem_ready;

	// ---------------------------------------------------------------
	// Sequencing
	// ---------------------------------------------------------------
	region_guard_pkg::guard_state_e state_r;
	region_guard_pkg::guard_state_e state_nxt;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			region_guard_pkg::ST_IDLE: begin
				if (take_w) begin
					state_nxt = pass_w ? region_guard_pkg::ST_MEM : region_guard_pkg::ST_RESP;
				end
			end
			region_guard_pkg::ST_MEM: begin
				if (mem_ready) begin
					state_nxt = region_guard_pkg::ST_RESP;
				end
			end
			region_guard_pkg::ST_RESP: begin
				state_nxt = region_guard_pkg::ST_IDLE;
			end
			default: begin
				state_nxt = region_guard_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r     <= region_guard_pkg::ST_IDLE;
			req_ready_r <= 1'b1;
		end else begin
			state_r     <= state_nxt;
			req_ready_r <= (state_nxt == region_guard_pkg::ST_IDLE);
		end
	end

	// Memory request only for permitted accesses
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_valid_r <= 1'b0;
			mem_addr_r  <= '0;
			mem_write_r <= 1'b0;
			mem_wdata_r <= '0;
		end else if (take_w && pass_w) begin
			mem_valid_r <= 1'b1;
			mem_addr_r  <= req_addr;
			mem_write_r <= req_write;
			mem_wdata_r <= req_wdata;
		end else if (mem_end_w) begin
			mem_valid_r <= 1'b0;
			mem_write_r <= 1'b0;
		end
	end

	// Completion or fault, never both
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			resp_done_r  <= 1'b0;
			resp_rdata_r <= '0;
		end else begin
			resp_done_r <= mem_end_w;
			if (mem_end_w) begin
				resp_rdata_r <= mem_rdata;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fault_r       <= 1'b0;
			fault_addr_r  <= '0;
			fault_write_r <= 1'b0;
		end else begin
			fault_r <= take_w && !pass_w;
			if (take_w && !pass_w) begin
				fault_addr_r  <= req_addr;
				fault_write_r <= req_write;
			end
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_cfg_store;
		@(posedge sys_clk) disable iff (!rst_b)
		cfg_hit_w |=> cfg_en_r[$past(cfg_idx)] == $past(cfg_en);
	endproperty
	a_cfg_store: assert property (p_cfg_store) else $error("region enable not stored");

	for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_sub_chk
		property p_sub_excl;
			@(posedge sys_clk) disable iff (!rst_b)
			in_range_w[g] && cfg_sub_dis_r[g][sub_idx_w[g]] && take_w && (hit_w == '0) |=> fault_r;
		endproperty
		a_sub_excl: assert property (p_sub_excl) else $error("excluded subregion passed");
	end

	property p_no_region;
		@(posedge sys_clk) disable iff (!rst_b)
		take_w && !any_hit_w |=> fault_r && !mem_valid_r ##1 req_ready_r;
	endproperty
	a_no_region: assert property (p_no_region) else $error("unmapped access not faulted");

	property p_denied;
		@(posedge sys_clk) disable iff (!rst_b)
		take_w && any_hit_w && !sel_allow_w |=> fault_r && fault_addr_r == $past(req_addr);
	endproperty
	a_denied: assert property (p_denied) else $error("forbidden access not faulted");

	property p_ro_read;
		@(posedge sys_clk) disable iff (!rst_b)
		take_w && any_hit_w && sel_perm_w == region_guard_pkg::PERM_RO && !req_write
		|=> mem_valid_r && !mem_write_r && !fault_r;
	endproperty
	a_ro_read: assert property (p_ro_read) else $error("read-only read refused");

	property p_ro_write;
		@(posedge sys_clk) disable iff (!rst_b)
		take_w && any_hit_w && sel_perm_w == region_guard_pkg::PERM_RO && req_write |=> fault_r && fault_write_r;
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write passed");

	property p_none;
		@(posedge sys_clk) disable iff (!rst_b)
		take_w && any_hit_w && sel_perm_w == region_guard_pkg::PERM_NONE |=> fault_r ##1 !fault_r;
	endproperty
	a_none: assert property (p_none) else $error("no-access region passed");

	property p_fault_excl;
		@(posedge sys_clk) disable iff (!rst_b)
		fault_r |-> !resp_done_r && !mem_valid_r && !$past(mem_valid_r);
	endproperty
	a_fault_excl: assert property (p_fault_excl) else $error("fault with memory activity");

	property p_mem_hold;
		@(posedge sys_clk) disable iff (!rst_b)
		mem_valid_r && !mem_ready |=> mem_valid_r && $stable(mem_addr_r) && $stable(mem_write_r);
	endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped");

	c_fault:     cover property (@(posedge sys_clk) disable iff (!rst_b) fault_r);
	c_write_ok:  cover property (@(posedge sys_clk) disable iff (!rst_b) resp_done_r && $past(mem_write_r));
	c_ro_read:   cover property (@(posedge sys_clk) disable iff (!rst_b)
		take_w && sel_perm_w == region_guard_pkg::PERM_RO && any_hit_w && !req_write);
	c_sub_block: cover property (@(posedge sys_clk) disable iff (!rst_b) take_w && (in_range_w & ~hit_w) != '0);

endmodule // memory_region_guard

// file: common/region_guard_pkg.sv
// Shared constants for the memory region guard
package region_guard_pkg;

	// ---------------------------------------------------------------
	// Region geometry
	// ---------------------------------------------------------------
	localparam int          MAX_REGIONS  = 8;
	localparam int          REGION_IDX_W = 3;
	localparam int          SUB_COUNT    = 8;
	localparam int          SUB_IDX_W    = 3;
	localparam int          SIZE_W       = 5;
	localparam logic [4:0]  SIZE_MIN     = 5'h03;

	// ---------------------------------------------------------------
	// Permission encodings
	// ---------------------------------------------------------------
	localparam int          PERM_W       = 2;
	localparam logic [1:0]  PERM_NONE    = 2'h0;
	localparam logic [1:0]  PERM_RO      = 2'h1;
	localparam logic [1:0]  PERM_RW      = 2'h2;

	// ---------------------------------------------------------------
	// Values after reset
	// ---------------------------------------------------------------
	localparam logic        REGION_EN_RST = 1'h0;
	localparam logic [1:0]  PERM_RST      = 2'h0;
	localparam logic [4:0]  SIZE_RST      = 5'h1F;
	localparam logic [7:0]  SUB_DIS_RST   = 8'h00;

	// ---------------------------------------------------------------
	// Guard state machine
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_MEM,
		ST_RESP
	} guard_state_e;

endpackage

// file: hdl/region_matcher.sv
// Address match and permission check for one protection region
`timescale 1ns/100ps
module region_matcher #(
	parameter int ADDR_W = 32
) (
	// Access under test
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              write,
	// Region settings
	input  wire logic              region_en,
	input  wire logic [ADDR_W-1:0] base,
	input  wire logic [4:0]        size_log2,
	input  wire logic [7:0]        sub_dis,
	input  wire logic [1:0]        perm,
	// Result
	output logic                   in_range,
	output logic                   hit,
	output logic                   allow,
	output logic [2:0]             sub_idx
);

	logic [4:0]        eff_size_w;
	logic [ADDR_W-1:0] mask_w;
	logic [ADDR_W-1:0] shifted_w;

	assign eff_size_w = (size_log2 < region_guard_pkg::SIZE_MIN) ? region_guard_pkg::SIZE_MIN : size_log2;
	assign mask_w     = {ADDR_W{1'b1}} << eff_size_w;
	// Top three offset bits pick one of eight equal parts
	assign shifted_w  = addr >> (eff_size_w - region_guard_pkg::SIZE_MIN);
	assign sub_idx    = shifted_w[2:0];
	assign in_range   = region_en && (((addr ^ base) & mask_w) == '0);
	assign hit        = in_range && !sub_dis[sub_idx];
	// Read-only passes reads only, none passes nothing
	assign allow      = (perm == region_guard_pkg::PERM_RW) ||
	                    ((perm == region_guard_pkg::PERM_RO) && !write);

endmodule // region_matcher

// file: verif/mem_partner.sv
// Behavioural memory answering the guard's memory-side handshake
`timescale 1ns/100ps
module mem_partner (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// Request from guard
	input  wire logic        valid,
	input  wire logic [31:0] addr,
	input  wire logic        write,
	input  wire logic [31:0] wdata,
	// Answer to guard
	output logic             ready_r,
	output logic [31:0]      rdata_r
);
	logic [31:0] store [logic [31:0]];
	logic [1:0]  wait_r;

	function automatic logic [31:0] peek(input logic [31:0] a);
		return store.exists(a) ? store[a] : a ^ 32'hA5A55A5A;
	endfunction

	// ---------------------------------------------------------------
	// Answer after 0 to 3 stall cycles, data toggles when not valid
	// ---------------------------------------------------------------
	always @(negedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ready_r <= 1'b0;
			wait_r  <= 2'h0;
			rdata_r <= 32'h00000000;
		end else if (valid && !ready_r && wait_r == addr[3:2]) begin
			ready_r <= 1'b1;
			wait_r  <= 2'h0;
			rdata_r <= peek(addr);
		end else begin
			ready_r <= 1'b0;
			wait_r  <= (valid && !ready_r) ? wait_r + 2'h1 : 2'h0;
			rdata_r <= ~rdata_r;
		end
	end

	always @(posedge sys_clk) begin
		if (rst_b && valid && ready_r && write)
			store[addr] = wdata;
	end
endmodule // mem_partner

// file: verif/tb.sv
// Self-checking testbench for the memory region guard
`timescale 1ns/100ps
module tb;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        cfg_we = 1'b0, cfg_en = 1'b0, req_valid = 1'b0, req_write = 1'b0;
	logic [2:0]  cfg_idx = 3'h0;
	logic [31:0] cfg_base = 32'h0, req_addr = 32'h0, req_wdata = 32'h0;
	logic [4:0]  cfg_size = 5'h00;
	logic [7:0]  cfg_sub_dis = 8'h00;
	logic [1:0]  cfg_perm = 2'h0;
	logic        req_ready_r, resp_done_r, fault_r, fault_write_r, mem_valid_r, mem_write_r, mem_ready;
	logic [31:0] resp_rdata_r, fault_addr_r, mem_addr_r, mem_wdata_r, mem_rdata;
	logic [65:0] exp_q [$];
	logic [65:0] x;
	logic [31:0] mirror [logic [31:0]];
	logic [1:0]  perm_a [8];
	logic [7:0]  sub_a [8];
	int          err_count = 0;
	int          total_checks = 0;
	localparam logic [1:0] PERM_TAB [8] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h1, 2'h0, 2'h2, 2'h3};

	always #5 sys_clk = ~sys_clk;

	memory_region_guard u_memory_region_guard (.sys_clk(sys_clk), .rst_b(rst_b), .cfg_we(cfg_we),
		.cfg_idx(cfg_idx), .cfg_en(cfg_en), .cfg_base(cfg_base), .cfg_size(cfg_size),
		.cfg_sub_dis(cfg_sub_dis), .cfg_perm(cfg_perm), .req_valid(req_valid), .req_addr(req_addr),
		.req_write(req_write), .req_wdata(req_wdata), .req_ready_r(req_ready_r),
		.resp_done_r(resp_done_r), .resp_rdata_r(resp_rdata_r), .fault_r(fault_r),
		.fault_addr_r(fault_addr_r), .fault_write_r(fault_write_r), .mem_valid_r(mem_valid_r),
		.mem_addr_r(mem_addr_r), .mem_write_r(mem_write_r), .mem_wdata_r(mem_wdata_r),
		.mem_ready(mem_ready), .mem_rdata(mem_rdata));

	mem_partner u_mem_partner (.sys_clk(sys_clk), .rst_b(rst_b), .valid(mem_valid_r), .addr(mem_addr_r),
		.write(mem_write_r), .wdata(mem_wdata_r), .ready_r(mem_ready), .rdata_r(mem_rdata));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic tally_and_finish;
		if (err_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (e !== s) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, e, s);
		end
	endtask

	task automatic chk_reset;
		chk("rst_ready", 32'h1, 32'(req_ready_r));
		chk("rst_fault", 32'h0, 32'(fault_r));
		chk("rst_done", 32'h0, 32'(resp_done_r));
		chk("rst_mem_valid", 32'h0, 32'(mem_valid_r));
	endtask

	task automatic cfg_region(input int k, input logic [1:0] p, input logic [7:0] s);
		@(negedge sys_clk);
		cfg_we      <= 1'b1;
		cfg_idx     <= k[2:0];
		cfg_en      <= 1'b1;
		cfg_base    <= 32'((k + 1) << 12) | 32'($urandom_range(255));
		cfg_size    <= 5'h08;
		cfg_sub_dis <= s;
		cfg_perm    <= p;
		perm_a[k] = p;
		sub_a[k]  = s;
		@(negedge sys_clk);
		cfg_we <= 1'b0;
	endtask

	task automatic access(input int k, input logic wr);
		logic [31:0] a, d, e;
		logic        f;
		int          n;
		a = 32'((k + 1) << 12) | 32'($urandom_range(63) << 2);
		d = $urandom;
		if (k == 8 || sub_a[k][a[7:5]])
			f = 1'b1;
		else if (perm_a[k] == region_guard_pkg::PERM_RW)
			f = 1'b0;
		else
			f = (perm_a[k] == region_guard_pkg::PERM_RO) ? wr : 1'b1;
		e = mirror.exists(a) ? mirror[a] : a ^ 32'hA5A55A5A;
		if (!f && wr)
			mirror[a] = d;
		exp_q.push_back({f, wr, a, e});
		req_valid <= 1'b1;
		req_addr  <= a;
		req_write <= wr;
		req_wdata <= d;
		n = 0;
		while (req_ready_r !== 1'b1 && n < 50) begin
			@(negedge sys_clk);
			n++;
		end
		chk("req_taken", 32'h1, 32'(n < 50));
		@(negedge sys_clk);
	endtask

	// ---------------------------------------------------------------
	// Result monitor
	// ---------------------------------------------------------------
	always @(negedge sys_clk) begin
		if (rst_b && mem_valid_r === 1'b1 && exp_q.size() > 0) begin
			chk("mem_valid_blocked", 32'h0, 32'(exp_q[0][65]));
			chk("mem_addr", exp_q[0][63:32], mem_addr_r);
			chk("mem_write", 32'(exp_q[0][64]), 32'(mem_write_r));
		end
		if (rst_b && (resp_done_r === 1'b1 || fault_r === 1'b1)) begin
			if (exp_q.size() == 0) begin
				chk("unexpected_answer", 32'h0, 32'h1);
			end else begin
				x = exp_q.pop_front();
				chk("fault", 32'(x[65]), 32'(fault_r));
				chk("done", 32'(!x[65]), 32'(resp_done_r));
				if (x[65]) begin
					chk("fault_addr", x[63:32], fault_addr_r);
					chk("fault_write", 32'(x[64]), 32'(fault_write_r));
				end else if (!x[64]) begin
					chk("rdata", x[31:0], resp_rdata_r);
				end
			end
		end
	end

	initial begin
		#100000;
		err_count++;
		tally_and_finish;
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(88857));
		for (int k = 0; k < 8; k++) begin
			perm_a[k] = region_guard_pkg::PERM_NONE;
			sub_a[k]  = 8'h00;
		end
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk_reset();
		rst_b <= 1'b1;
		for (int k = 0; k < 8; k++)
			access(k, 1'($urandom_range(1)));
		req_valid <= 1'b0;
		for (int k = 0; k < 8; k++)
			cfg_region(k, PERM_TAB[k], k[0] ? 8'h01 << k : 8'h00);
		repeat (300)
			access($urandom_range(8), 1'($urandom_range(1)));
		req_valid <= 1'b0;
		for (int k = 0; k < 8; k++)
			cfg_region(k, region_guard_pkg::PERM_RW, 8'h00);
		repeat (150)
			access($urandom_range(8), 1'b0);
		req_valid <= 1'b0;
		repeat (20) @(negedge sys_clk);
		chk("queue_empty", 32'h0, 32'(exp_q.size()));
		// Mid-run reset: regions return to disabled, every access faults
		rst_b <= 1'b0;
		repeat (2) @(negedge sys_clk);
		chk_reset();
		rst_b <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			perm_a[k] = region_guard_pkg::PERM_NONE;
			sub_a[k]  = 8'h00;
		end
		for (int k = 0; k < 8; k++)
			access(k, 1'($urandom_range(1)));
		req_valid <= 1'b0;
		repeat (20) @(negedge sys_clk);
		chk("queue_empty_rst", 32'h0, 32'(exp_q.size()));
		tally_and_finish;
	end
endmodule // tb
